// >>> pkg/flash_cmd_pkg.sv
package flash_cmd_pkg;

    // Opcodes handled by this command group
    localparam logic [7:0] OP_READ_SEC = 8'h48;
    localparam logic [7:0] OP_ID_DUAL = 8'h92;
    localparam logic [7:0] OP_ID_QUAD = 8'h94;
    localparam logic [7:0] OP_UNIQUE_ID = 8'h4b;
    localparam logic [7:0] OP_SET_PARAM = 8'hc0;
    localparam logic [7:0] OP_BURST_WRAP = 8'h0c;
    localparam logic [7:0] OP_ENTER_QUAD = 8'h38;
    localparam logic [7:0] OP_EXIT_QUAD = 8'hff;

    // Lane counts of a transfer phase
    localparam logic [2:0] LANE_1 = 3'h1;
    localparam logic [2:0] LANE_2 = 3'h2;
    localparam logic [2:0] LANE_4 = 3'h4;

    // Phase lengths in serial clocks
    localparam int CNT_W = 6;
    localparam logic [5:0] CLK_BYTE_X1 = 6'h08;
    localparam logic [5:0] CLK_BYTE_X2 = 6'h04;
    localparam logic [5:0] CLK_BYTE_X4 = 6'h02;
    localparam logic [5:0] CLK_ADDR_X1 = 6'h18;
    localparam logic [5:0] CLK_ADDR_X4 = 6'h06;
    localparam logic [5:0] CLK_ADDR_MODE_X2 = 6'h10;
    localparam logic [5:0] CLK_ADDR_MODE_X4 = 6'h08;
    localparam logic [5:0] CLK_DUMMY_SEC = 6'h08;
    localparam logic [5:0] CLK_DUMMY_ID_X4 = 6'h04;
    localparam logic [5:0] CLK_DUMMY_UID = 6'h20;
    localparam logic [5:0] CLK_NONE = 6'h00;

    // Security register pages (address bits 15..8)
    localparam int SEC_PAGES = 3;
    localparam int SEC_BYTES = 256;
    localparam logic [7:0] SEC_PAGE1 = 8'h10;
    localparam logic [7:0] SEC_PAGE2 = 8'h20;
    localparam logic [7:0] SEC_PAGE3 = 8'h30;
    localparam logic [7:0] UNDEF_BYTE = 8'hff;

    // Read-parameter byte and wrap-setting byte fields
    localparam int PARAM_DUMMY_HI = 5;
    localparam int PARAM_DUMMY_LO = 4;
    localparam int PARAM_WRAP_HI = 1;
    localparam int PARAM_WRAP_LO = 0;
    localparam int WRAP_SET_HI = 6;
    localparam int WRAP_SET_LO = 5;
    localparam logic [1:0] DUMMY_SEL_RESET = 2'h0;
    localparam logic [1:0] WRAP_SEL_RESET = 2'h0;
    localparam logic [23:0] WRAP_BASE_BYTES = 24'h000008;
    localparam int UID_BYTES = 8;

    // Core-to-link load word: kind, page, byte, data
    localparam int LOAD_W = 19;
    localparam int LOAD_KIND = 18;
    localparam int LOAD_PAGE_HI = 17;
    localparam int LOAD_PAGE_LO = 16;
    localparam int LOAD_BYTE_HI = 15;
    localparam int LOAD_BYTE_LO = 8;
    localparam int LOAD_DATA_HI = 7;
    localparam int LOAD_DATA_LO = 0;

    typedef enum logic [2:0] {SRC_NONE, SRC_SEC, SRC_ID, SRC_UID, SRC_BURST, SRC_PARAM} source_e;
    typedef enum logic [2:0] {PH_CMD, PH_ADDR, PH_DUMMY, PH_OUT, PH_IDLE} phase_e;

    typedef struct packed {
        logic [2:0] inLanes;
        logic [5:0] addrClks;
        logic [5:0] dummyClks;
        logic [2:0] outLanes;
        logic useDummySel;
        source_e src;
    } cmd_s;

    localparam cmd_s CMD_IDLE = '{LANE_1, CLK_NONE, CLK_NONE, LANE_1, 1'b0, SRC_NONE};

endpackage

// >>> pkg/load_if.sv
interface load_if
    import flash_cmd_pkg::*;
#(
    parameter int W = LOAD_W
);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    logic strobe;
    logic [W-1:0] dataOut;

    modport user (output valid, output data, input ready, input strobe, input dataOut);
    modport cdc (input valid, input data, output ready, output strobe, output dataOut);
endinterface

// >>> rtl/load_crossing.sv
module load_crossing
    import flash_cmd_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic sclk,
    load_if.cdc port
);
    logic reqT;
    logic [LOAD_W-1:0] held;
    logic ackS1;
    logic ackS2;
    logic reqS1;
    logic reqS2;
    logic reqS3;

    ////////////////////////////////////////////////////////////////
    // Core side: a word is taken only when the last toggle is echoed
    assign port.ready = (reqT == ackS2);

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            reqT <= 1'b0;
            held <= '0;
        end
        else if (ce && port.valid && port.ready)
        begin
            reqT <= ~reqT;
            held <= port.data;
        end
    end

    // Echo back from the link side
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ackS1 <= 1'b0;
            ackS2 <= 1'b0;
        end
        else if (ce)
        begin
            ackS1 <= reqS3;
            ackS2 <= ackS1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Link side: the serial clock may stop, so a word waits for edges
    always_ff @(posedge sclk or posedge rst)
    begin
        if (rst)
        begin
            reqS1 <= 1'b0;
            reqS2 <= 1'b0;
            reqS3 <= 1'b0;
        end
        else
        begin
            reqS1 <= reqT;
            reqS2 <= reqS1;
            reqS3 <= reqS2;
        end
    end

    // Held word is stable since before the toggle arrived
    assign port.strobe = reqS2 ^ reqS3;
    assign port.dataOut = held;

endmodule // load_crossing

// >>> rtl/flash_cmd_engine.sv
// Notes on behaviour
// - Sample on rise, drive on fall, MSB first
// - Security byte address increments, wraps FFh to 00h
// - Pages 10h/20h/30h; others give undefined data
// - Output streams until chip select rises
// - 92h: dual address and mode, dual ID out
// - 94h: quad address, mode, four dummy clocks
// - Manufacturer and device bytes alternate
// - 4Bh, four dummy bytes, 64-bit unique number
// - C0h accepted only in quad command mode
// - Dummy selector gives 2/4/6/8 clocks
// - Wrap selector gives 8/16/32/64 bytes
// - Reset gives 8-byte wrap, 2 dummy clocks
// - Serial wrap from 77h bits, kept across modes
// - 0Ch wraps inside aligned wrap window
// - Power up serial; one mode at a time
// - 38h enters quad mode only with quad enable
// - FFh in quad mode returns to serial
// - Mode switch keeps wrap length
module flash_cmd_engine
    import flash_cmd_pkg::*;
#(
    parameter logic [7:0] MFR_ID = 8'h5a, // Arbitrary value
    parameter logic [7:0] DEV_ID = 8'h3c, // Arbitrary value
    parameter logic [63:0] UNIQUE_ID = 64'h0123456789abcdef // Arbitrary value
)(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic quadEnableBit,
    input wire logic loadValid,
    output logic loadReady,
    input wire logic loadIsWrap,
    input wire logic [1:0] loadPage,
    input wire logic [7:0] loadByte,
    input wire logic [7:0] loadData,
    output logic quadCommandMode,
    input wire logic sclk,
    input wire logic csN,
    input wire logic [3:0] ioIn,
    output logic [3:0] ioOut,
    output logic [3:0] ioOe,
    output logic [23:0] burstAddr,
    input wire logic [7:0] burstData
);

    ////////////////////////////////////////////////////////////////
    // Helper functions

    // Clocks needed to move one byte over the given lanes
    function automatic logic [5:0] byteClocks(input logic [2:0] lanes);
        logic [5:0] c;
        c = CLK_BYTE_X1;
        if (lanes == LANE_2)
            c = CLK_BYTE_X2;
        else if (lanes == LANE_4)
            c = CLK_BYTE_X4;
        return c;
    endfunction

    // Shift incoming lanes in, lowest lane last
    function automatic logic [31:0] shiftLanes(input logic [31:0] sh, input logic [3:0] io,
                                               input logic [2:0] lanes);
        logic [31:0] r;
        r = {sh[30:0], io[0]};
        if (lanes == LANE_2)
            r = {sh[29:0], io[1:0]};
        else if (lanes == LANE_4)
            r = {sh[27:0], io[3:0]};
        return r;
    endfunction

    // Output enables for the lanes in use; serial data leaves on lane 1
    function automatic logic [3:0] laneMask(input logic [2:0] lanes);
        logic [3:0] m;
        m = 4'h2;
        if (lanes == LANE_2)
            m = 4'h3;
        else if (lanes == LANE_4)
            m = 4'hf;
        return m;
    endfunction

    // Command table; anything not listed is ignored till chip select rises
    function automatic cmd_s decodeCmd(input logic [7:0] op, input logic quad);
        cmd_s c;
        c = CMD_IDLE;
        if (!quad)
        begin
            if (op == OP_READ_SEC)
                c = '{LANE_1, CLK_ADDR_X1, CLK_DUMMY_SEC, LANE_1, 1'b0, SRC_SEC};
            else if (op == OP_ID_DUAL)
                c = '{LANE_2, CLK_ADDR_MODE_X2, CLK_NONE, LANE_2, 1'b0, SRC_ID};
            else if (op == OP_ID_QUAD)
                c = '{LANE_4, CLK_ADDR_MODE_X4, CLK_DUMMY_ID_X4, LANE_4, 1'b0, SRC_ID};
            else if (op == OP_UNIQUE_ID)
                c = '{LANE_1, CLK_NONE, CLK_DUMMY_UID, LANE_1, 1'b0, SRC_UID};
        end
        else
        begin
            // burst read framed like quad fast read
            if (op == OP_BURST_WRAP)
                c = '{LANE_4, CLK_ADDR_X4, CLK_NONE, LANE_4, 1'b1, SRC_BURST};
            else if (op == OP_SET_PARAM)
                c = '{LANE_4, CLK_BYTE_X4, CLK_NONE, LANE_4, 1'b0, SRC_PARAM};
        end
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////
    // Declarations

    phase_e phase;
    cmd_s cmd;
    cmd_s decoded;
    logic [5:0] cnt;
    logic [31:0] shiftIn;
    logic [31:0] nextShift;
    logic [23:0] baseAddr;
    logic [2:0] inLanes;
    logic [5:0] dummyLen;
    logic opLast;
    logic addrLast;
    logic paramDone;
    logic quadMode;
    logic [1:0] dummySel;
    logic [1:0] wrapSel;
    logic qeS1;
    logic qeS2;
    logic modeS1;
    logic modeS2;
    logic [7:0] secMem [SEC_PAGES*SEC_BYTES];
    logic [7:0] outShift;
    logic [5:0] bitCnt;
    logic [7:0] byteCnt;
    logic [7:0] nextByte;
    logic [23:0] wrapMask;
    logic [9:0] secIndex;
    logic secValid;
    logic [2:0] uidIdx;

    load_if loadPort ();

    ////////////////////////////////////////////////////////////////
    // Core-side loads of security bytes and 77h wrap settings

    assign loadPort.valid = loadValid;
    assign loadPort.data = {loadIsWrap, loadPage, loadByte, loadData};
    assign loadReady = loadPort.ready;

    load_crossing crossing (
        .core_clk (core_clk),
        .rst (rst),
        .ce (ce),
        .sclk (sclk),
        .port (loadPort.cdc)
    );

    // Mode seen by the core, two flops from the link domain
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            modeS1 <= 1'b0;
            modeS2 <= 1'b0;
        end
        else if (ce)
        begin
            modeS1 <= quadMode;
            modeS2 <= modeS1;
        end
    end

    assign quadCommandMode = modeS2;

    ////////////////////////////////////////////////////////////////
    // Link-side decode

    // Quad enable comes from core logic; settles well before an opcode ends
    always_ff @(posedge sclk or posedge rst)
    begin
        if (rst)
        begin
            qeS1 <= 1'b0;
            qeS2 <= 1'b0;
        end
        else
        begin
            qeS1 <= quadEnableBit;
            qeS2 <= qeS1;
        end
    end

    // Opcode lanes follow the active mode
    assign inLanes = (phase == PH_CMD) ? (quadMode ? LANE_4 : LANE_1) : cmd.inLanes;
    assign nextShift = shiftLanes(shiftIn, ioIn, inLanes);
    assign decoded = decodeCmd(nextShift[7:0], quadMode);
    assign opLast = (phase == PH_CMD) && (cnt == byteClocks(inLanes) - 6'h01);
    assign addrLast = (phase == PH_ADDR) && (cnt == cmd.addrClks - 6'h01);
    assign paramDone = addrLast && (cmd.src == SRC_PARAM);

    assign dummyLen = cmd.useDummySel ? ({3'h0, dummySel, 1'b0} + 6'h02) : cmd.dummyClks;

    ////////////////////////////////////////////////////////////////
    // Frame sequencer: chip select high clears the frame at once

    // inputs taken on the rising edge
    always_ff @(posedge sclk or posedge rst or posedge csN)
    begin
        if (rst || csN)
        begin
            phase <= PH_CMD;
            cmd <= CMD_IDLE;
            cnt <= '0;
            shiftIn <= '0;
            baseAddr <= '0;
        end
        else
        begin
            unique case (phase)
                PH_CMD:
                begin
                    shiftIn <= nextShift;
                    cnt <= cnt + 6'h01;
                    if (opLast)
                    begin
                        cmd <= decoded;
                        cnt <= '0;
                        if (decoded.src == SRC_NONE)
                            phase <= PH_IDLE;
                        else if (decoded.addrClks == CLK_NONE)
                            phase <= PH_DUMMY;
                        else
                            phase <= PH_ADDR;
                    end
                end
                PH_ADDR:
                begin
                    shiftIn <= nextShift;
                    cnt <= cnt + 6'h01;
                    if (addrLast)
                    begin
                        cnt <= '0;
                        // identification address arrives ahead of the mode byte
                        baseAddr <= (cmd.src == SRC_ID) ? nextShift[31:8] : nextShift[23:0];
                        if (cmd.src == SRC_PARAM)
                            phase <= PH_IDLE;
                        else if (dummyLen == CLK_NONE)
                            phase <= PH_OUT;
                        else
                            phase <= PH_DUMMY;
                    end
                end
                PH_DUMMY:
                begin
                    cnt <= cnt + 6'h01;
                    if (cnt == dummyLen - 6'h01)
                        phase <= PH_OUT;
                end
                PH_OUT:
                begin
                    // stays here until chip select rises
                    cnt <= cnt;
                end
                PH_IDLE:
                begin
                    cnt <= cnt;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // Persistent settings, cleared only by the device reset

    // serial mode after reset, a single mode flag
    always_ff @(posedge sclk or posedge rst)
    begin
        if (rst)
            quadMode <= 1'b0;
        else if (opLast)
        begin
            if (!quadMode && nextShift[7:0] == OP_ENTER_QUAD && qeS2)
                quadMode <= 1'b1;
            else if (quadMode && nextShift[7:0] == OP_EXIT_QUAD)
                quadMode <= 1'b0;
        end
    end

    always_ff @(posedge sclk or posedge rst)
    begin
        if (rst)
        begin
            dummySel <= DUMMY_SEL_RESET;
            wrapSel <= WRAP_SEL_RESET;
        end
        else if (paramDone)
        begin
            dummySel <= nextShift[PARAM_DUMMY_HI:PARAM_DUMMY_LO];
            wrapSel <= nextShift[PARAM_WRAP_HI:PARAM_WRAP_LO];
        end
        // wrap bits from 77h; mode changes leave this untouched
        else if (loadPort.strobe && loadPort.dataOut[LOAD_KIND])
            wrapSel <= loadPort.dataOut[WRAP_SET_HI:WRAP_SET_LO];
    end

    // mode flag is the only state a switch alters
    // Security bytes loaded from the core; flop storage, index by page and byte
    always_ff @(posedge sclk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < SEC_PAGES*SEC_BYTES; i++)
                secMem[i] <= UNDEF_BYTE;
        end
        else if (loadPort.strobe && !loadPort.dataOut[LOAD_KIND])
            secMem[{loadPort.dataOut[LOAD_PAGE_HI:LOAD_PAGE_LO],
                    loadPort.dataOut[LOAD_BYTE_HI:LOAD_BYTE_LO]}]
                <= loadPort.dataOut[LOAD_DATA_HI:LOAD_DATA_LO];
    end

    ////////////////////////////////////////////////////////////////
    // Byte sources

    // page decode; upper byte must be zero
    always_comb
    begin
        secValid = (baseAddr[23:16] == 8'h00);
        secIndex = {2'h0, baseAddr[7:0] + byteCnt};
        if (baseAddr[15:8] == SEC_PAGE2)
            secIndex[9:8] = 2'h1;
        else if (baseAddr[15:8] == SEC_PAGE3)
            secIndex[9:8] = 2'h2;
        else if (baseAddr[15:8] != SEC_PAGE1)
            secValid = 1'b0;
    end

    // window of 8 << selector bytes
    assign wrapMask = (WRAP_BASE_BYTES << wrapSel) - 24'h000001;
    assign burstAddr = (baseAddr & ~wrapMask) | ((baseAddr + {16'h0000, byteCnt}) & wrapMask);

    // unique number repeats every eight bytes
    assign uidIdx = byteCnt[2:0];

    always_comb
    begin
        nextByte = UNDEF_BYTE;
        unique case (cmd.src)
            // 8-bit offset rolls FFh to 00h
            SRC_SEC: nextByte = secValid ? secMem[secIndex] : UNDEF_BYTE;
            // alternate, starting from address bit 0
            SRC_ID: nextByte = (baseAddr[0] ^ byteCnt[0]) ? DEV_ID : MFR_ID;
            SRC_UID: nextByte = UNIQUE_ID[8*(UID_BYTES-1-int'(uidIdx)) +: 8];
            SRC_BURST: nextByte = burstData;
            SRC_NONE, SRC_PARAM: nextByte = UNDEF_BYTE;
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // Output shifter on the falling edge

    // MSB first, changing on the falling edge
    always_ff @(negedge sclk or posedge rst or posedge csN)
    begin
        // chip select high releases the lines at once
        if (rst || csN)
        begin
            outShift <= '0;
            bitCnt <= '0;
            byteCnt <= '0;
            ioOe <= '0;
        end
        else if (phase == PH_OUT)
        begin
            ioOe <= laneMask(cmd.outLanes);
            if (bitCnt == CLK_NONE)
            begin
                outShift <= nextByte;
                bitCnt <= byteClocks(cmd.outLanes) - 6'h01;
                // next byte address after each byte
                byteCnt <= byteCnt + 8'h01;
            end
            else
            begin
                outShift <= outShift << cmd.outLanes;
                bitCnt <= bitCnt - 6'h01;
            end
        end
    end

    // Top bits of the shifter onto the active lanes
    always_comb
    begin
        ioOut = {2'h0, outShift[7], 1'b0};
        if (cmd.outLanes == LANE_2)
            ioOut = {2'h0, outShift[7:6]};
        else if (cmd.outLanes == LANE_4)
            ioOut = outShift[7:4];
    end

endmodule // flash_cmd_engine

// >>> verif/flash_cmd_sva.sv
module flash_cmd_sva (
    input logic core_clk,
    input logic rst,
    input logic ce,
    input logic quadEnableBit,
    input logic loadValid,
    input logic loadReady,
    input logic quadCommandMode,
    input logic sclk,
    input logic csN,
    input logic [3:0] ioOe
);
    timeunit 1ns;
    timeprecision 100ps;
    ////////////////////////////////////////
    // Deselected device leaves every line free
    property p_oe_idle;
        @(posedge core_clk) disable iff (rst) csN && $past(csN) |-> ioOe == 4'h0;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("enable while deselected");
    // Only serial, dual or quad lane sets
    property p_oe_set;
        @(posedge core_clk) disable iff (rst) ioOe inside {4'h0, 4'h2, 4'h3, 4'hf};
    endproperty
    a_oe_set: assert property (p_oe_set) else $error("odd lane set");
    // Lane set holds for the frame; only a frame end clears it
    property p_oe_hold;
        @(posedge sclk) disable iff (rst) ioOe != 4'h0 |=> ioOe == $past(ioOe) || ioOe == 4'h0;
    endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("lane set changed");
    // Dual identity output only exists in serial mode
    property p_dual_serial;
        @(posedge core_clk) disable iff (rst) ioOe == 4'h3 |-> !quadCommandMode;
    endproperty
    a_dual_serial: assert property (p_dual_serial) else $error("dual in quad");
    // Quad mode entry needs the enable bit
    property p_qe_gate;
        @(posedge core_clk) disable iff (rst) $rose(quadCommandMode) |-> $past(quadEnableBit, 4);
    endproperty
    a_qe_gate: assert property (p_qe_gate) else $error("quad without enable");
    property p_rst_state;
        @(posedge core_clk) disable iff (rst)
            $fell(rst) |-> !quadCommandMode && ioOe == 4'h0 && loadReady;
    endproperty
    a_rst_state: assert property (p_rst_state) else $error("bad state after reset");
    // A taken word blocks the port until its echo
    property p_load_take;
        @(posedge core_clk) disable iff (rst) loadValid && loadReady && ce |=> !loadReady;
    endproperty
    a_load_take: assert property (p_load_take) else $error("load not taken");
    property p_load_back;
        @(posedge core_clk) disable iff (rst) $fell(loadReady) |-> ##[1:200] loadReady;
    endproperty
    a_load_back: assert property (p_load_back) else $error("load never done");
    c_quad: cover property (@(posedge core_clk) disable iff (rst) $rose(quadCommandMode));
    c_quad_out: cover property (@(posedge core_clk) disable iff (rst) ioOe == 4'hf);
    c_ser_out: cover property (@(posedge core_clk) disable iff (rst) ioOe == 4'h2);
endmodule // flash_cmd_sva

bind flash_cmd_engine flash_cmd_sva u_sva (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .quadEnableBit(quadEnableBit),
    .loadValid(loadValid),
    .loadReady(loadReady),
    .quadCommandMode(quadCommandMode),
    .sclk(sclk),
    .csN(csN),
    .ioOe(ioOe)
);

// >>> verif/flash_host_model.sv
module flash_host_model (
    output logic sclk,
    output logic csN,
    output logic [3:0] ioIn,
    input logic [3:0] ioOut
);
    timeunit 1ns;
    timeprecision 100ps;
    // Clock parks low outside frames
    initial
    begin
        sclk = 1'b0;
        csN = 1'b1;
        ioIn = 4'h0;
    end
    task automatic open_frame();
        csN = 1'b0;
        #62.5;
    endtask
    // MSB first, lanes
    // Unused lines flip each clock so stale bits never pass as data
    task automatic send(input logic [63:0] val, input int bits, input int lanes);
        logic [3:0] nxt;
        for (int i = bits - lanes; i >= 0; i -= lanes)
        begin
            nxt = ~ioIn;
            for (int j = 0; j < lanes; j++)
                nxt[j] = val[i + j];
            ioIn = nxt;
            #62.5 sclk = 1'b1;
            #62.5 sclk = 1'b0;
        end
    endtask
    task automatic take(output logic [63:0] val, input int bits, input int lanes);
        val = '0;
        for (int i = 0; i < bits; i += lanes)
        begin
            ioIn = ~ioIn;
            #62.5 sclk = 1'b1;
            val = (val << lanes) | (lanes == 4 ? 64'(ioOut) :
                lanes == 2 ? 64'(ioOut[1:0]) : 64'(ioOut[1]));
            #62.5 sclk = 1'b0;
        end
    endtask
    task automatic close_frame();
        #62.5 csN = 1'b1;
        #62.5;
    endtask
endmodule // flash_host_model

// >>> verif/tb_flash_id_secreg_qpi_commands.sv
module tb_flash_id_secreg_qpi_commands
    import flash_cmd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] MFR = 8'h6e; // Arbitrary value
    localparam logic [7:0] DEV = 8'h91; // Arbitrary value
    localparam logic [63:0] UID = 64'hfedc0123a5a55a5a; // Arbitrary value
    logic core_clk = 1'b0;
    logic rst = 1'b0;
    logic quadEnableBit = 1'b0;
    logic loadValid = 1'b0;
    logic loadIsWrap = 1'b0;
    logic [1:0] loadPage = 2'h0;
    logic [7:0] loadByte = 8'h00;
    logic [7:0] loadData = 8'h00;
    logic loadReady, quadCommandMode, sclk, csN;
    logic [3:0] ioIn, ioOut, ioOe, oeSeen;
    logic [23:0] burstAddr;
    logic [7:0] burstData;
    logic [63:0] got;
    int bad_count = 0;
    int samples_checked = 0;
    ////////////////////////////////////////
    initial
    begin
        forever #12.5 core_clk = ~core_clk;
    end
    // Array stand-in: each byte is its address plus 40h
    assign burstData = burstAddr[7:0] + 8'h40;
    flash_cmd_engine #(.MFR_ID(MFR), .DEV_ID(DEV), .UNIQUE_ID(UID)) DUT (
        .core_clk(core_clk), .rst(rst), .ce(1'b1), .quadEnableBit(quadEnableBit),
        .loadValid(loadValid), .loadReady(loadReady), .loadIsWrap(loadIsWrap),
        .loadPage(loadPage), .loadByte(loadByte), .loadData(loadData),
        .quadCommandMode(quadCommandMode), .sclk(sclk), .csN(csN), .ioIn(ioIn),
        .ioOut(ioOut), .ioOe(ioOe), .burstAddr(burstAddr), .burstData(burstData)
    );
    flash_host_model host (.sclk(sclk), .csN(csN), .ioIn(ioIn), .ioOut(ioOut));
    ////////////////////////////////////////
    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("FAIL %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("mismatches %0d, comparisons %0d", bad_count, samples_checked);
        if (bad_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // The crossing only completes while sclk runs, so a dummy frame rides along
    task automatic load(input logic wrap, input logic [1:0] page, input logic [7:0] a,
        input logic [7:0] d);
        int n;
        fork
            begin
                @(negedge core_clk);
                loadValid = 1'b1;
                loadIsWrap = wrap;
                loadPage = page;
                loadByte = a;
                loadData = d;
                @(negedge core_clk);
                loadValid = 1'b0;
            end
            begin
                host.open_frame();
                host.send(64'h0, 16, 1);
                host.close_frame();
            end
        join
        n = 0;
        while (loadReady !== 1'b1 && n < 100)
        begin
            @(negedge core_clk);
            n++;
        end
        if (n == 100)
        begin
            bad_count++;
            finish_test();
        end
    endtask
    // One framed command: opcode, header, dummy clocks, then read back
    task automatic xfer(input logic [7:0] op, input logic [63:0] hdr, input int hBits,
        input int lanes, input int dummy, input int rBits);
        host.open_frame();
        host.send({56'h0, op}, 8, quadCommandMode === 1'b1 ? 4 : 1);
        if (hBits > 0) host.send(hdr, hBits, lanes);
        if (dummy > 0) host.send(64'h0, dummy, 1);
        if (rBits > 0) host.take(got, rBits, lanes);
        #20;
        oeSeen = ioOe;
        host.close_frame();
    endtask
    ////////////////////////////////////////
    initial
    begin
        // A real edge, so link-side flops reset while the serial clock is parked
        rst <= 1'b1;
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        check(quadCommandMode, 1'b0, "reset mode");
        check(ioOe, 4'h0, "reset enables");
        check(loadReady, 1'b1, "reset ready");
        load(1'b0, 2'h0, 8'hff, 8'ha5);
        load(1'b0, 2'h0, 8'h00, 8'h5c);
        load(1'b1, 2'h0, 8'h00, 8'h20);
        xfer(OP_READ_SEC, 64'h0010ff, 24, 1, 8, 24);
        check(got[23:0], 24'ha55cff, "security wrap");
        check(oeSeen, 4'h2, "serial enables");
        check(ioOe, 4'h0, "released");
        xfer(OP_READ_SEC, 64'h0110ff, 24, 1, 8, 8);
        check(got[7:0], UNDEF_BYTE, "undefined page");
        xfer(OP_ID_DUAL, 64'hf0, 32, 2, 0, 32);
        check(got[31:0], {MFR, DEV, MFR, DEV}, "dual id");
        check(oeSeen, 4'h3, "dual enables");
        xfer(OP_ID_QUAD, 64'hf0, 32, 4, 4, 32);
        check(got[31:0], {MFR, DEV, MFR, DEV}, "quad id");
        check(oeSeen, 4'hf, "quad enables");
        xfer(OP_UNIQUE_ID, 64'h0, 0, 1, 32, 64);
        check(got, UID, "unique id");
        // Refused here, so the first burst must still see the reset dummy count
        xfer(OP_SET_PARAM, 64'h33, 8, 1, 0, 0);
        xfer(OP_ENTER_QUAD, 64'h0, 0, 1, 0, 0);
        check(quadCommandMode, 1'b0, "entry without enable");
        @(negedge core_clk);
        quadEnableBit = 1'b1;
        xfer(OP_ENTER_QUAD, 64'h0, 0, 1, 0, 0);
        check(quadCommandMode, 1'b1, "entry");
        xfer(OP_BURST_WRAP, 64'h00001e, 24, 4, 2, 32);
        check(got[31:0], 32'h5e5f5051, "burst 16 default dummy");
        xfer(OP_ID_QUAD, 64'hf0, 32, 4, 4, 32);
        check(oeSeen, 4'h0, "serial command in quad");
        xfer(OP_SET_PARAM, 64'h23, 8, 4, 0, 0);
        xfer(OP_BURST_WRAP, 64'h00003e, 24, 4, 6, 32);
        check(got[31:0], 32'h7e7f4041, "burst 64");
        xfer(OP_EXIT_QUAD, 64'h0, 0, 4, 0, 0);
        check(quadCommandMode, 1'b0, "exit");
        finish_test();
    end
endmodule // tb_flash_id_secreg_qpi_commands
